// file: dv/frc_ext_src.sv
// External count clock source model for the timer's count pin
module frc_ext_src (
  input wire logic clk, // CPU clock
  input wire logic load, // Start a burst
  input wire logic init_lvl, // Pin level before the burst
  input wire logic [7:0] n_edges, // Transitions in the burst
  input wire logic [3:0] gap, // Cycles between transitions, 4 at the least
  output logic pin, // Count pin, held still between bursts
  output logic busy // Burst in progress
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left;
  logic [3:0] cnt;
  assign busy = (left != 8'h00);
  initial begin
    pin = 1'b1;
    left = 8'h00;
    cnt = 4'h0;
  end
  always @(posedge clk) begin
    if (load) begin
      pin <= init_lvl;
      left <= n_edges;
      cnt <= 4'h0;
    end else if (busy) begin
      cnt <= cnt + 4'h1;
      // Clamp: never faster than the counter can follow
      if (cnt + 4'h1 >= ((gap < 4'h4) ? 4'h4 : gap)) begin
        pin <= ~pin;
        left <= left - 8'h01;
        cnt <= 4'h0;
      end
    end
  end
endmodule

// file: dv/tb_top.sv
// Self-checking bench for the free-running counter
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, resetn, psel, penable, pwrite, ext_bonded, halt, irq_mask;
  logic pready, pslverr, ovf_irq, src_pin, src_load, src_lvl, src_busy;
  logic [7:0] paddr, src_n;
  logic [31:0] pwdata, prdata;
  logic [3:0] src_gap;
  int miscompares, n_compared;

  frc_timer dut_u (.REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .EXT_COUNT_PIN(src_pin), .EXT_PIN_BONDED(ext_bonded),
    .HALT_MODE(halt), .GLOBAL_IRQ_MASK(irq_mask), .OVF_IRQ(ovf_irq));
  frc_ext_src src_u (.clk(ref_clk), .load(src_load), .init_lvl(src_lvl), .n_edges(src_n),
    .gap(src_gap), .pin(src_pin), .busy(src_busy));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
      miscompares++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int i;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      chk("apb ready", 32'h1, 32'h0);
      summarize();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  // Active transitions seen in n toggles starting from level s
  function automatic int ext_exp(int s, int ed, int n);
    return ((s == 0) == (ed == 1)) ? (n + 1) / 2 : n / 2;
  endfunction

  initial begin
    logic [31:0] q;
    logic e;
    logic [15:0] c;
    logic [7:0] hi;
    int m, k, s, ed, en;
    logic [1:0] sel [3];
    sel = '{frc_pkg::CC_DIV2, frc_pkg::CC_DIV4, frc_pkg::CC_DIV8};
    void'($urandom(32'h122f_b2ad));
    {miscompares, n_compared} = {32'sd0, 32'sd0};
    {psel, penable, pwrite, src_load, src_lvl, irq_mask} = 6'h00;
    {paddr, pwdata, src_n, src_gap} = 52'h0;
    {ext_bonded, halt, resetn} = 3'b110;
    tick(12);
    resetn <= 1'b1;
    rd_chk("ctrl", frc_pkg::OFS_CTRL, 32'h0);
    rd_chk("status", frc_pkg::OFS_STATUS, 32'h0);
    rd_chk("cnt hi", frc_pkg::OFS_CNT_HI, 32'h0000_00FF);
    rd_chk("cnt lo", frc_pkg::OFS_CNT_LO, 32'h0000_00FC);
    apb(1'b0, 8'h18, 32'h0, q, e);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    for (int dv = 0; dv < 3; dv++) begin
      m = $urandom_range(250, 10);
      en = $urandom_range(1, 0);
      wr(frc_pkg::OFS_CTRL, 32'(sel[dv]) | (32'(en) << frc_pkg::CTRL_OVIE_BIT));
      wr((dv == 1) ? frc_pkg::OFS_SHD_LO : frc_pkg::OFS_CNT_LO, $urandom);
      halt <= 1'b0;
      tick(m << (dv + 1));
      halt <= 1'b1;
      c = 16'hFFFC + m[15:0];
      rd_chk("shd hi", frc_pkg::OFS_SHD_HI, {24'h0, c[15:8]});
      rd_chk("shd lo", frc_pkg::OFS_SHD_LO, {24'h0, c[7:0]});
      rd_chk("cnt lo", frc_pkg::OFS_CNT_LO, {24'h0, c[7:0]});
      rd_chk("ovf set", frc_pkg::OFS_STATUS, 32'h1);
      irq_mask <= 1'($urandom);
      tick(2);
      chk("irq", {31'h0, ovf_irq}, 32'(en & !irq_mask));
      rd_chk("shd lo", frc_pkg::OFS_SHD_LO, {24'h0, c[7:0]});
      rd_chk("ovf kept", frc_pkg::OFS_STATUS, 32'h1);
      if (dv == 0) wr(frc_pkg::OFS_CNT_LO, 32'h0);
      else rd_chk("cnt lo", frc_pkg::OFS_CNT_LO, {24'h0, c[7:0]});
      rd_chk("ovf clr", frc_pkg::OFS_STATUS, 32'h0);
      chk("irq off", {31'h0, ovf_irq}, 32'h0);
    end
    wr(frc_pkg::OFS_CTRL, 32'(frc_pkg::CC_DIV2));
    for (int p = 0; p < 2; p++) begin
      hi = p ? frc_pkg::OFS_SHD_HI : frc_pkg::OFS_CNT_HI;
      wr(hi + 8'h04, 32'h0);
      rd_chk("seq hi", hi, 32'h0000_00FF);
      m = $urandom_range(200, 4);
      halt <= 1'b0;
      tick(2 * m);
      halt <= 1'b1;
      c = 16'hFFFC + m[15:0];
      rd_chk("seq hi2", hi, {24'h0, c[15:8]});
      rd_chk("seq lo", hi + 8'h04, 32'h0000_00FC);
      rd_chk("live lo", hi + 8'h04, {24'h0, c[7:0]});
    end
    for (int i = 0; i < 5; i++) begin
      s = $urandom_range(1, 0);
      ed = $urandom_range(1, 0);
      m = $urandom_range(20, 1);
      src_lvl <= 1'(s);
      src_n <= 8'h00;
      src_load <= 1'b1;
      ext_bonded <= (i != 4);
      halt <= 1'b0;
      tick(1);
      src_load <= 1'b0;
      tick(8);
      halt <= 1'b1;
      wr(frc_pkg::OFS_SHD_LO, 32'h0);
      wr(frc_pkg::OFS_CTRL, 32'(frc_pkg::CC_EXT) | (32'(ed) << frc_pkg::CTRL_EDGE_BIT));
      halt <= 1'b0;
      src_n <= 8'(m);
      src_gap <= 4'($urandom);
      src_load <= 1'b1;
      tick(1);
      src_load <= 1'b0;
      // Busy rises on the same edge that takes the load
      tick(1);
      for (k = 0; k < 400 && src_busy !== 1'b0; k++) tick(1);
      if (k == 400) begin
        chk("ext burst done", 32'h0, 32'h1);
        summarize();
      end
      tick(8);
      halt <= 1'b1;
      c = 16'hFFFC + ((i != 4) ? 16'(ext_exp(s, ed, m)) : 16'h0);
      rd_chk("ext hi", frc_pkg::OFS_SHD_HI, {24'h0, c[15:8]});
      rd_chk("ext lo", frc_pkg::OFS_SHD_LO, {24'h0, c[7:0]});
    end
    wr(frc_pkg::OFS_CTRL, 32'(frc_pkg::CC_DIV4));
    halt <= 1'b0;
    tick(30);
    resetn <= 1'b0;
    tick(2);
    halt <= 1'b1;
    resetn <= 1'b1;
    rd_chk("wake hi", frc_pkg::OFS_CNT_HI, 32'h0000_00FF);
    rd_chk("wake lo", frc_pkg::OFS_CNT_LO, 32'h0000_00FC);
    summarize();
  end
endmodule

// file: include/frc_pkg.sv
// Constants for the 16-bit free-running counter block
package frc_pkg;
  // APB byte addresses
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CNT_HI = 8'h08;
  localparam logic [7:0] OFS_CNT_LO = 8'h0C;
  localparam logic [7:0] OFS_SHD_HI = 8'h10;
  localparam logic [7:0] OFS_SHD_LO = 8'h14;

  // Control and status register fields
  localparam int CTRL_CC_LSB = 0;
  localparam int CTRL_EDGE_BIT = 2;
  localparam int CTRL_OVIE_BIT = 3;
  localparam int CTRL_WIDTH = 4;
  localparam int STATUS_OVF_BIT = 0;

  // Clock select encodings
  localparam logic [1:0] CC_DIV2 = 2'h0;
  localparam logic [1:0] CC_DIV4 = 2'h1;
  localparam logic [1:0] CC_DIV8 = 2'h2;
  localparam logic [1:0] CC_EXT = 2'h3;

  // Values after reset, and the top count
  localparam logic [15:0] COUNT_RESET = 16'hFFFC;
  localparam logic [15:0] COUNT_TOP = 16'hFFFF;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [2:0] PRESC_RESET = 3'h0;
endpackage

// file: rtl/frc_timer.sv
// Free-running 16-bit counter with prescaler, external clock and APB slave
//
// The register addresses and the APB register port were left to the implementer.
module frc_timer (
  input wire logic REF_CLK, // CPU clock
  input wire logic RESETN, // Async reset, active low
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB enable
  input wire logic PWRITE, // APB direction
  input wire logic [7:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic EXT_COUNT_PIN, // External counter clock pin
  input wire logic EXT_PIN_BONDED, // High when the pin is bonded out
  input wire logic HALT_MODE, // Processor in HALT
  input wire logic GLOBAL_IRQ_MASK, // CPU interrupt mask bit
  output logic OVF_IRQ // Overflow interrupt request
);

  // Register state
  logic [15:0] count;
  logic [15:0] next_count;
  logic [7:0] latch_low;
  logic [7:0] next_latch_low;
  logic latch_valid;
  logic next_latch_valid;
  logic ovf_flag;
  logic next_ovf_flag;
  logic clear_armed;
  logic next_clear_armed;
  logic [frc_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [frc_pkg::CTRL_WIDTH-1:0] next_ctrl;
  logic [31:0] rdata;
  logic [31:0] next_rdata;

  // Clock source state
  logic [2:0] presc;
  logic [2:0] next_presc;
  logic sync_a;
  logic sync_b;
  logic sync_c;
  logic next_sync_a;
  logic next_sync_b;
  logic next_sync_c;

  logic [1:0] clock_select_bits;
  logic ext_edge_select;
  logic overflow_irq_enable;
  logic pin_level;
  logic ext_tick;
  logic presc_tick;
  logic cnt_tick;
  logic setup_rd;
  logic access_wr;
  logic addr_ok;
  logic low_write;
  logic flag_set;
  logic flag_clr;

  function automatic logic frc_div_tick(input logic [1:0] sel, input logic [2:0] pre);
    logic t;
    t = 1'b0;
    case (sel)
      frc_pkg::CC_DIV2: t = pre[0];
      frc_pkg::CC_DIV4: t = &pre[1:0];
      frc_pkg::CC_DIV8: t = &pre;
      default: t = 1'b0;
    endcase
    return t;
  endfunction

  function automatic logic frc_is_mapped(input logic [7:0] a);
    return (a == frc_pkg::OFS_CTRL) || (a == frc_pkg::OFS_STATUS) ||
           (a == frc_pkg::OFS_CNT_HI) || (a == frc_pkg::OFS_CNT_LO) ||
           (a == frc_pkg::OFS_SHD_HI) || (a == frc_pkg::OFS_SHD_LO);
  endfunction

  assign clock_select_bits = ctrl[frc_pkg::CTRL_CC_LSB +: 2];
  assign ext_edge_select = ctrl[frc_pkg::CTRL_EDGE_BIT];
  assign overflow_irq_enable = ctrl[frc_pkg::CTRL_OVIE_BIT];

  // APB: zero wait states, reads sampled in the setup cycle
  assign addr_ok = frc_is_mapped(PADDR);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~addr_ok;
  assign PRDATA = rdata;
  assign setup_rd = PSEL & ~PENABLE & ~PWRITE;
  assign access_wr = PSEL & PENABLE & PWRITE;
  assign low_write = access_wr &&
                     (PADDR == frc_pkg::OFS_CNT_LO || PADDR == frc_pkg::OFS_SHD_LO);

  // Unbonded pin floats to one
  assign pin_level = EXT_PIN_BONDED ? EXT_COUNT_PIN : 1'b1;

  // Edge on synchronised copies only; relies on four clocks between edges
  assign ext_tick = ext_edge_select ? (sync_b & ~sync_c) : (~sync_b & sync_c);
  assign presc_tick = frc_div_tick(clock_select_bits, presc);

  // WAIT has no effect; only HALT stops the count
  assign cnt_tick = ~HALT_MODE &
                    ((clock_select_bits == frc_pkg::CC_EXT) ? ext_tick : presc_tick);

  assign OVF_IRQ = ovf_flag & overflow_irq_enable & ~GLOBAL_IRQ_MASK;

  // Clock source next state
  always_comb begin
    next_sync_a = pin_level;
    next_sync_b = sync_a;
    next_sync_c = sync_b;
    // Prescaler frozen in HALT so the phase survives a wake by interrupt
    next_presc = HALT_MODE ? presc : presc + 3'h1;
  end

  // Prescaler starts from a fixed phase so twin instances stay aligned
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      presc <= frc_pkg::PRESC_RESET;
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      sync_c <= 1'b1;
    end else begin
      presc <= next_presc;
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
      sync_c <= next_sync_c;
    end
  end

  // Counter, read sequence, flag and registers
  always_comb begin
    next_count = count;
    next_latch_low = latch_low;
    next_latch_valid = latch_valid;
    next_clear_armed = clear_armed;
    next_ctrl = ctrl;
    next_rdata = rdata;
    flag_set = 1'b0;
    flag_clr = 1'b0;

    if (cnt_tick) begin
      next_count = count + 16'h0001;
      if (count == frc_pkg::COUNT_TOP) begin
        flag_set = 1'b1;
      end
    end

    if (setup_rd) begin
      next_rdata = 32'h0000_0000;
      case (PADDR)
        frc_pkg::OFS_CTRL: next_rdata[frc_pkg::CTRL_WIDTH-1:0] = ctrl;
        frc_pkg::OFS_STATUS: begin
          next_rdata[frc_pkg::STATUS_OVF_BIT] = ovf_flag;
          if (ovf_flag) begin
            next_clear_armed = 1'b1;
          end
        end
        frc_pkg::OFS_CNT_HI, frc_pkg::OFS_SHD_HI: begin
          next_rdata[7:0] = count[15:8];
          // Only the first high read of a sequence captures
          if (!latch_valid) begin
            next_latch_low = count[7:0];
            next_latch_valid = 1'b1;
          end
        end
        frc_pkg::OFS_CNT_LO, frc_pkg::OFS_SHD_LO: begin
          next_rdata[7:0] = latch_valid ? latch_low : count[7:0];
          next_latch_valid = 1'b0;
          if (PADDR == frc_pkg::OFS_CNT_LO && clear_armed) begin
            flag_clr = 1'b1;
            next_clear_armed = 1'b0;
          end
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end

    if (access_wr) begin
      if (PADDR == frc_pkg::OFS_CTRL) begin
        next_ctrl = PWDATA[frc_pkg::CTRL_WIDTH-1:0];
      end
      if (PADDR == frc_pkg::OFS_CNT_LO && clear_armed) begin
        flag_clr = 1'b1;
        next_clear_armed = 1'b0;
      end
    end

    // Reload beats a same-cycle tick
    if (low_write) begin
      next_count = frc_pkg::COUNT_RESET;
    end

    // A rollover in the clearing cycle keeps the flag
    next_ovf_flag = flag_set | (ovf_flag & ~flag_clr);
  end

  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      count <= frc_pkg::COUNT_RESET;
      latch_low <= 8'h00;
      latch_valid <= 1'b0;
      ovf_flag <= 1'b0;
      clear_armed <= 1'b0;
      ctrl <= frc_pkg::CTRL_RESET;
      rdata <= 32'h0000_0000;
    end else begin
      count <= next_count;
      latch_low <= next_latch_low;
      latch_valid <= next_latch_valid;
      ovf_flag <= next_ovf_flag;
      clear_armed <= next_clear_armed;
      ctrl <= next_ctrl;
      rdata <= next_rdata;
    end
  end

  // Checks
  logic rd_shd_lo;
  logic rd_any_lo;
  assign rd_shd_lo = setup_rd && (PADDR == frc_pkg::OFS_SHD_LO);
  assign rd_any_lo = setup_rd && (PADDR == frc_pkg::OFS_CNT_LO || PADDR == frc_pkg::OFS_SHD_LO);
  logic rd_any_hi;
  logic main_lo_access;
  logic [7:0] cnt_lo_byte;
  logic [7:0] cnt_hi_byte;
  logic [frc_pkg::CTRL_WIDTH-1:0] wdata_ctrl;
  assign rd_any_hi = setup_rd && (PADDR == frc_pkg::OFS_CNT_HI || PADDR == frc_pkg::OFS_SHD_HI);
  // Only the main low byte takes part in the clearing handshake
  assign main_lo_access = (setup_rd || access_wr) && (PADDR == frc_pkg::OFS_CNT_LO);
  assign cnt_lo_byte = count[7:0];
  assign cnt_hi_byte = count[15:8];
  assign wdata_ctrl = PWDATA[frc_pkg::CTRL_WIDTH-1:0];

  a_low_write_reload: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    low_write |=> count == 16'hFFFC)
    else $error("low byte write did not reload counter");

  a_reset_count: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !$past(RESETN) |-> (count == 16'hFFFC || count == 16'hFFFD))
    else $error("counter did not start from reload value");

  a_rollover_flag: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (cnt_tick && count == 16'hFFFF && !low_write) |=> (ovf_flag && count == 16'h0000))
    else $error("rollover did not set overflow flag");

  a_irq_masked: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (GLOBAL_IRQ_MASK || !ovf_flag || !overflow_irq_enable) |-> !OVF_IRQ)
    else $error("interrupt raised while masked or idle");

  a_irq_pending: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (ovf_flag && overflow_irq_enable && !GLOBAL_IRQ_MASK) |-> OVF_IRQ)
    else $error("pending overflow interrupt not raised");

  a_halt_freeze: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (HALT_MODE && !low_write) |=> count == $past(count))
    else $error("counter moved during halt");

  a_latch_hold: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (latch_valid && !rd_any_lo) |=> (latch_valid && latch_low == $past(latch_low)))
    else $error("latched low byte changed before low read");

  a_shadow_flag: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (rd_shd_lo && ovf_flag) |=> ovf_flag)
    else $error("shadow low read cleared overflow flag");

  a_clear_armed: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    $fell(ovf_flag) |-> $past(clear_armed))
    else $error("overflow flag cleared without status read");

  a_ext_step: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (clock_select_bits == frc_pkg::CC_EXT && !HALT_MODE && !low_write)
      |=> count == $past(count) + {15'h0000, $past(ext_tick)})
    else $error("external mode count step wrong");

  a_ext_single: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    ext_tick |=> !ext_tick)
    else $error("external edge gave more than one pulse");

  a_div2_rate: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (clock_select_bits == frc_pkg::CC_DIV2 && !HALT_MODE && !$past(HALT_MODE))
      |-> presc_tick != $past(presc_tick))
    else $error("divide by two tick pattern wrong");

  a_high_capture: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (rd_any_hi && !latch_valid) |=> (latch_valid && latch_low == $past(cnt_lo_byte)))
    else $error("high read did not capture low byte");

  a_low_latched: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (rd_any_lo && latch_valid) |=> (!latch_valid && PRDATA[7:0] == $past(latch_low)))
    else $error("low read did not return latched byte");

  a_low_live: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (rd_any_lo && !latch_valid) |=> PRDATA[7:0] == $past(cnt_lo_byte))
    else $error("low read did not return live byte");

  a_high_read: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    rd_any_hi |=> (PRDATA[7:0] == $past(cnt_hi_byte) && PRDATA[31:8] == 24'h00_0000))
    else $error("high read returned wrong byte");

  a_status_arm: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (setup_rd && PADDR == frc_pkg::OFS_STATUS && ovf_flag) |=> clear_armed)
    else $error("status read with flag set did not arm clear");

  a_main_low_clear: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (main_lo_access && clear_armed && !flag_set) |=> (!ovf_flag && !clear_armed))
    else $error("armed main low access did not clear flag");

  a_pending_kept: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (ovf_flag && !(main_lo_access && clear_armed)) |=> ovf_flag)
    else $error("pending overflow dropped without clear");

  a_set_wins: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    flag_set |=> ovf_flag)
    else $error("rollover lost against clear");

  a_flag_source: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    $rose(ovf_flag) |-> $past(count) == frc_pkg::COUNT_TOP)
    else $error("overflow flag set without rollover");

  a_unbonded_one: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !EXT_PIN_BONDED |=> sync_a)
    else $error("unbonded pin not read as one");

  a_presc_step: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (presc_tick && !HALT_MODE && !low_write) |=> count == $past(count) + 16'h0001)
    else $error("prescaled tick did not advance counter");

  a_halt_presc: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    HALT_MODE |=> presc == $past(presc))
    else $error("prescaler moved during halt");

  a_edge_dir: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    ext_tick |-> sync_b == ext_edge_select)
    else $error("external pulse on wrong edge");

  a_ctrl_write: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (access_wr && PADDR == frc_pkg::OFS_CTRL) |=> ctrl == $past(wdata_ctrl))
    else $error("control write not taken");

  a_div4_gap: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (clock_select_bits == frc_pkg::CC_DIV4 && presc_tick && !HALT_MODE) |=> !presc_tick)
    else $error("divide by four ticks too close");

  a_div8_wrap: assert property (@(posedge REF_CLK) disable iff (!RESETN)
    (clock_select_bits == frc_pkg::CC_DIV8 && presc_tick && !HALT_MODE) |=> presc == 3'h0)
    else $error("divide by eight phase wrong");

  c_overflow: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    flag_set && overflow_irq_enable);

  c_coherent_read: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    latch_valid && cnt_tick ##[1:50] rd_any_lo);

  c_ext_count: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    clock_select_bits == frc_pkg::CC_EXT && cnt_tick);

  c_flag_clear: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    $fell(ovf_flag));

  c_halt_wake: cover property (@(posedge REF_CLK) disable iff (!RESETN)
    $fell(HALT_MODE) && count != frc_pkg::COUNT_RESET);

endmodule
